// ### tps_mem_model.sv
// memory partner answering the sequencer's word fetches
`timescale 1ns/1ps
module tps_mem_model (
    input  wire logic        sys_clk_i,
    input  wire logic        mem_req_i,
    input  wire logic [31:0] mem_addr_i,
    output logic             mem_ack_o,
    output logic [31:0]      mem_rdata_o
);
    logic [31:0] mem [0:511];
    int          wait_q = 0;
    initial mem_ack_o = 1'b0;
    initial mem_rdata_o = 32'h0;
    always @(posedge sys_clk_i) begin
        mem_ack_o <= 1'b0;
        // between answers the last word is inverted every cycle
        mem_rdata_o <= ~mem_rdata_o;
        if (mem_req_i && !mem_ack_o) begin
            if (wait_q == 0) begin
                mem_ack_o <= 1'b1;
                mem_rdata_o <= mem[mem_addr_i[10:2]];
                wait_q <= $urandom_range(0, 3);
            end else
                wait_q <= wait_q - 1;
        end
    end
endmodule // tps_mem_model

// ### tps_pkg.sv
// constants shared by the timed playback sequencer files
package tps_pkg;
    // register byte addresses
    localparam logic [11:0] TPS_OFS_FIRST_BLK = 12'h800;
    localparam logic [11:0] TPS_OFS_CUR_BLK   = 12'h804;
    localparam logic [11:0] TPS_OFS_CONTROL_STATUS_WORD_ONE      = 12'h808;
    localparam logic [11:0] TPS_OFS_CTRL      = 12'h830;
    localparam logic [11:0] TPS_OFS_CLK_HI    = 12'h834;
    localparam logic [11:0] TPS_OFS_CLK_LO    = 12'h838;
    // control_status_word_one fields
    localparam int TPS_CSR_START     = 0;
    localparam int TPS_CSR_STOPPED   = 1;
    localparam int TPS_CSR_PB_ENABLE = 4;
    localparam int TPS_CSR_TRIG_ARM  = 5;
    localparam int TPS_CSR_STOP_IEN  = 14;
    // engine control word fields
    localparam int TPS_CTL_GLOBAL_ON = 0;
    localparam int TPS_CTL_NO_CLR    = 1;
    localparam int TPS_CTL_SKIP_BACK = 2;
    localparam int TPS_CTL_FORCE_TRG = 3;
    localparam logic [31:0] TPS_RST_WORD = 32'h0000_0000;
    // control block and packet word offsets
    localparam logic [1:0] TPS_BLK_NEXT  = 2'h0;
    localparam logic [1:0] TPS_BLK_TABLE = 2'h1;
    localparam logic [1:0] TPS_BLK_COUNT = 2'h2;
    localparam logic [1:0] TPS_PKT_T_HI  = 2'h0;
    localparam logic [1:0] TPS_PKT_T_LO  = 2'h1;
    localparam logic [1:0] TPS_PKT_DATA  = 2'h2;
    localparam logic [1:0] TPS_LAST_WORD = 2'h2;
    localparam logic [31:0] TPS_PKT_BYTES = 32'h0000_000c;
    // timing
    localparam int TPS_CLK_PERIOD_NS = 40;
    localparam int TPS_CLK_RES_NS    = 20;
    localparam int TPS_CLK_STEP      = TPS_CLK_PERIOD_NS / TPS_CLK_RES_NS;
    localparam int TPS_RESTART_NS    = 20000;
    localparam int TPS_GUARD_CYC     =
        (TPS_RESTART_NS + TPS_CLK_PERIOD_NS - 1) / TPS_CLK_PERIOD_NS;
    localparam int TPS_START_MAX_NS  = 250000;
    localparam int TPS_HALF_BIT_NS   = 5000;
    localparam int TPS_HALF_BIT_CYC  = TPS_HALF_BIT_NS / TPS_CLK_PERIOD_NS;
    localparam int TPS_WORD_BITS     = 32;
    // line driver patterns
    localparam logic [1:0] TPS_LINE_TRI  = 2'h3;
    localparam logic [1:0] TPS_LINE_HIGH = 2'h2;
    localparam logic [1:0] TPS_LINE_LOW  = 2'h1;
    localparam logic [1:0] TPS_LINE_MID  = 2'h0;
endpackage

// ### tps_sequencer.sv
// timed playback sequencer: AHB-Lite registers, block walker, play clock
// Summary of operation
// - packet time and data go to encoder; sent once time <= play clock
// - skip option drops packets strictly older than clock, no interrupt
// - loaded packet starts sending within 10 us of its time
// - relative mode clears play clock to zero at start
// - later packet stalls processing; comparison repeats until due
// - all timing control bits zero means relative timing
// - absolute mode keeps preset clock at start; software presets it
// - start begins at block held in first-block address register
// - each newly sequenced block address goes to current pointer
// - halt on null next pointer or cleared start zeroes pointer
// - cleared start finishes current block, pending time included
// - start bit zero puts line driver in tri-state once the sequencer is idle or in stop
// - block transmission begins within 250 us of start
// - stopped set after all work done; software clears before restart
// - enable ignored while normal transmit runs; global on needed
// - trigger-start holds transmission until a trigger event
// - forced trigger starts armed channels within 50 us of each other
// - with trigger sync, first packet preloaded and held until due
// - stop interrupt enable raises interrupt on any stop
`timescale 1ns/1ps
module tps_sequencer
    import tps_pkg::*;
#(
    parameter int TW        = 64,
    parameter int GUARD_CYC = TPS_GUARD_CYC,
    parameter int HALF_CYC  = TPS_HALF_BIT_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             mem_req_o,
    output logic [31:0]      mem_addr_o,
    input  wire logic        mem_ack_i,
    input  wire logic [31:0] mem_rdata_i,
    input  wire logic        trig_i,
    input  wire logic        normal_tx_busy_i,
    output logic [1:0]       tx_line_o,
    output logic             stop_irq_o
);
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HDR  = 3'b001,
        S_PKT  = 3'b010,
        S_EVAL = 3'b011,
        S_BEND = 3'b100,
        S_STOP = 3'b101
    } tps_seq_st_t;

    // software-side registers
    logic [31:0]   first_q, first_d;
    logic          start_q, start_d;
    logic          stopped_q, stopped_d;
    logic          pb_en_q, pb_en_d;
    logic          trg_arm_q, trg_arm_d;
    logic          stop_ien_q, stop_ien_d;
    logic          glob_on_q, glob_on_d;
    logic          no_clr_q, no_clr_d;
    logic          skip_q, skip_d;
    logic          force_q, force_d;
    logic          go_pend_q, go_pend_d;
    logic          wr_q, wr_d;
    logic [11:0]   waddr_q, waddr_d;
    logic [31:0]   rdata_q, rdata_d;
    logic          preset_hi_w, preset_lo_w;
    // sequencer state
    tps_seq_st_t   st_q, st_d;
    logic [31:0]   cur_q, cur_d;
    logic [31:0]   next_q, next_d;
    logic [31:0]   tbl_q, tbl_d;
    logic [31:0]   left_q, left_d;
    logic [1:0]    widx_q, widx_d;
    logic [31:0]   thi_q, thi_d;
    logic [31:0]   tlo_q, tlo_d;
    logic [31:0]   pdat_q, pdat_d;
    logic [TW-1:0] pbclk_q, pbclk_d;
    logic          armed_q, armed_d;
    logic          trigd_q, trigd_d;
    logic [15:0]   guard_q, guard_d;
    logic          irq_q, irq_d;
    // trigger pin synchroniser
    logic          trg_s1_q, trg_s2_q, trg_s3_q;

    logic          addr_ok, start_go, trig_evt, running, clk_run;
    logic          enc_load, enc_busy, enc_start;
    logic [1:0]    enc_line;
    logic [TW-1:0] pkt_time;

    // zero-wait slave, single register per aligned word
    assign addr_ok   = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_q;

    assign pkt_time = TW'({thi_q, tlo_q});
    assign trig_evt = (trg_s2_q && !trg_s3_q) || force_q;
    // enable bit only counts while normal transmit is quiet
    assign start_go = (st_q == S_IDLE) && go_pend_q && pb_en_q &&
        glob_on_q && !normal_tx_busy_i;
    assign running  = (st_q != S_IDLE) && (st_q != S_STOP);
    assign clk_run  = running && (!armed_q || trigd_q);
    assign preset_hi_w = wr_q && (waddr_q == TPS_OFS_CLK_HI);
    assign preset_lo_w = wr_q && (waddr_q == TPS_OFS_CLK_LO);

    // register bus group
    always_comb begin
        first_d = first_q; start_d = start_q; stopped_d = stopped_q;
        pb_en_d = pb_en_q; trg_arm_d = trg_arm_q; stop_ien_d = stop_ien_q;
        glob_on_d = glob_on_q; no_clr_d = no_clr_q; skip_d = skip_q;
        force_d = 1'b0; go_pend_d = go_pend_q && !start_go;
        wr_d = addr_ok && hwrite;
        waddr_d = addr_ok ? haddr[11:0] : waddr_q;
        rdata_d = rdata_q;
        if (addr_ok && !hwrite) begin
            unique case (haddr[11:0])
                TPS_OFS_FIRST_BLK: rdata_d = first_q;
                TPS_OFS_CUR_BLK:   rdata_d = cur_q;
                TPS_OFS_CONTROL_STATUS_WORD_ONE: begin
                    rdata_d = TPS_RST_WORD;
                    rdata_d[TPS_CSR_START]     = start_q;
                    rdata_d[TPS_CSR_STOPPED]   = stopped_q;
                    rdata_d[TPS_CSR_PB_ENABLE] = pb_en_q;
                    rdata_d[TPS_CSR_TRIG_ARM]  = trg_arm_q;
                    rdata_d[TPS_CSR_STOP_IEN]  = stop_ien_q;
                end
                TPS_OFS_CTRL: begin
                    rdata_d = TPS_RST_WORD;
                    rdata_d[TPS_CTL_GLOBAL_ON] = glob_on_q;
                    rdata_d[TPS_CTL_NO_CLR]    = no_clr_q;
                    rdata_d[TPS_CTL_SKIP_BACK] = skip_q;
                end
                TPS_OFS_CLK_HI: rdata_d = 32'(pbclk_q >> 32);
                TPS_OFS_CLK_LO: rdata_d = pbclk_q[31:0];
                default:        rdata_d = TPS_RST_WORD;
            endcase
        end
        if (wr_q) begin
            unique case (waddr_q)
                TPS_OFS_FIRST_BLK: first_d = hwdata;
                TPS_OFS_CONTROL_STATUS_WORD_ONE: begin
                    start_d    = hwdata[TPS_CSR_START];
                    pb_en_d    = hwdata[TPS_CSR_PB_ENABLE];
                    trg_arm_d  = hwdata[TPS_CSR_TRIG_ARM];
                    stop_ien_d = hwdata[TPS_CSR_STOP_IEN];
                    if (hwdata[TPS_CSR_STOPPED]) begin
                        stopped_d = 1'b0;
                    end
                    if (hwdata[TPS_CSR_START] && !start_q) begin
                        go_pend_d = 1'b1;
                    end
                    if (!hwdata[TPS_CSR_START]) begin
                        go_pend_d = 1'b0;
                    end
                end
                TPS_OFS_CTRL: begin
                    glob_on_d = hwdata[TPS_CTL_GLOBAL_ON];
                    no_clr_d  = hwdata[TPS_CTL_NO_CLR];
                    skip_d    = hwdata[TPS_CTL_SKIP_BACK];
                    force_d   = hwdata[TPS_CTL_FORCE_TRG];
                end
                default: ;
            endcase
        end
        // hardware set wins over a clear in the same cycle
        if (st_q == S_STOP && guard_q == 16'h0000) begin
            stopped_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            // all-zero reset selects relative timing
            first_q <= TPS_RST_WORD; start_q <= 1'b0; stopped_q <= 1'b0;
            pb_en_q <= 1'b0; trg_arm_q <= 1'b0; stop_ien_q <= 1'b0;
            glob_on_q <= 1'b0; no_clr_q <= 1'b0; skip_q <= 1'b0;
            force_q <= 1'b0; go_pend_q <= 1'b0; wr_q <= 1'b0;
            waddr_q <= 12'h000; rdata_q <= TPS_RST_WORD;
        end else begin
            first_q <= first_d; start_q <= start_d; stopped_q <= stopped_d;
            pb_en_q <= pb_en_d; trg_arm_q <= trg_arm_d;
            stop_ien_q <= stop_ien_d; glob_on_q <= glob_on_d;
            no_clr_q <= no_clr_d; skip_q <= skip_d; force_q <= force_d;
            go_pend_q <= go_pend_d; wr_q <= wr_d; waddr_q <= waddr_d;
            rdata_q <= rdata_d;
        end
    end

    // sequencer group
    always_comb begin
        st_d = st_q; cur_d = cur_q; next_d = next_q; tbl_d = tbl_q;
        left_d = left_q; widx_d = widx_q; thi_d = thi_q; tlo_d = tlo_q;
        pdat_d = pdat_q; armed_d = armed_q; guard_d = guard_q;
        trigd_d = trigd_q || (armed_q && trig_evt);
        irq_d = 1'b0; enc_load = 1'b0;
        pbclk_d = clk_run ? pbclk_q + TW'(TPS_CLK_STEP) : pbclk_q;
        if (preset_hi_w) begin
            pbclk_d = TW'({hwdata, pbclk_q[31:0]});
        end else if (preset_lo_w) begin
            pbclk_d = TW'({pbclk_q[TW-1:32], hwdata});
        end
        unique case (st_q)
            S_IDLE: begin
                if (start_go) begin
                    st_d = S_HDR; widx_d = 2'h0;
                    cur_d = first_q;
                    armed_d = trg_arm_q; trigd_d = 1'b0;
                    if (!no_clr_q) begin
                        pbclk_d = '0;
                    end
                end
            end
            S_HDR: begin
                if (mem_ack_i) begin
                    widx_d = widx_q + 2'h1;
                    unique case (widx_q)
                        TPS_BLK_NEXT:  next_d = mem_rdata_i;
                        TPS_BLK_TABLE: tbl_d  = mem_rdata_i;
                        default:       left_d = mem_rdata_i;
                    endcase
                    if (widx_q == TPS_LAST_WORD) begin
                        widx_d = 2'h0;
                        st_d = (mem_rdata_i == 32'h0000_0000) ? S_BEND : S_PKT;
                    end
                end
            end
            S_PKT: begin
                if (mem_ack_i) begin
                    widx_d = widx_q + 2'h1;
                    unique case (widx_q)
                        TPS_PKT_T_HI: thi_d  = mem_rdata_i;
                        TPS_PKT_T_LO: tlo_d  = mem_rdata_i;
                        default:      pdat_d = mem_rdata_i;
                    endcase
                    if (widx_q == TPS_LAST_WORD) begin
                        widx_d = 2'h0;
                        st_d = S_EVAL;
                    end
                end
            end
            S_EVAL: begin
                // one packet in flight: the next waits for the encoder
                if (skip_q && (pkt_time < pbclk_q)) begin
                    left_d = left_q - 32'h0000_0001;
                    tbl_d = tbl_q + TPS_PKT_BYTES;
                    st_d = (left_q == 32'h0000_0001) ? S_BEND : S_PKT;
                end else if (!enc_busy) begin
                    enc_load = 1'b1;
                    left_d = left_q - 32'h0000_0001;
                    tbl_d = tbl_q + TPS_PKT_BYTES;
                    st_d = (left_q == 32'h0000_0001) ? S_BEND : S_PKT;
                end
            end
            S_BEND: begin
                // block ends only once the last packet has gone out
                if (!enc_busy) begin
                    if (start_q && next_q != 32'h0000_0000) begin
                        cur_d = next_q;
                        st_d = S_HDR;
                    end else begin
                        cur_d = 32'h0000_0000;
                        guard_d = 16'(GUARD_CYC);
                        st_d = S_STOP;
                    end
                end
            end
            S_STOP: begin
                if (guard_q == 16'h0000) begin
                    st_d = S_IDLE;
                    irq_d = stop_ien_q;
                end else begin
                    guard_d = guard_q - 16'h0001;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st_q <= S_IDLE; cur_q <= 32'h0000_0000; next_q <= 32'h0000_0000;
            tbl_q <= 32'h0000_0000; left_q <= 32'h0000_0000; widx_q <= 2'h0;
            thi_q <= 32'h0000_0000; tlo_q <= 32'h0000_0000;
            pdat_q <= 32'h0000_0000; pbclk_q <= '0; armed_q <= 1'b0;
            trigd_q <= 1'b0; guard_q <= 16'h0000; irq_q <= 1'b0;
            trg_s1_q <= 1'b0; trg_s2_q <= 1'b0; trg_s3_q <= 1'b0;
        end else begin
            st_q <= st_d; cur_q <= cur_d; next_q <= next_d; tbl_q <= tbl_d;
            left_q <= left_d; widx_q <= widx_d; thi_q <= thi_d;
            tlo_q <= tlo_d; pdat_q <= pdat_d; pbclk_q <= pbclk_d;
            armed_q <= armed_d; trigd_q <= trigd_d; guard_q <= guard_d;
            irq_q <= irq_d;
            trg_s1_q <= trig_i; trg_s2_q <= trg_s1_q; trg_s3_q <= trg_s2_q;
        end
    end

    assign mem_req_o  = (st_q == S_HDR) || (st_q == S_PKT);
    assign mem_addr_o = ((st_q == S_HDR) ? cur_q : tbl_q) + {28'h0000000,
        widx_q, 2'b00};
    assign tx_line_o  = start_q || running ? enc_line : TPS_LINE_TRI;
    assign stop_irq_o = irq_q;

    tps_tx_encoder #(
        .TW       (TW),
        .HALF_CYC (HALF_CYC)
    ) u_enc (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .load_i    (enc_load),
        .time_i    (pkt_time),
        .data_i    (pdat_q),
        .go_i      (clk_run),
        .pb_clk_i  (pbclk_q),
        .busy_o    (enc_busy),
        .start_o   (enc_start),
        .line_o    (enc_line)
    );

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_tristate_when_off: assert property (!start_q &&
        st_q == S_IDLE |-> tx_line_o == TPS_LINE_TRI)
        else $error("line driven while stopped");
    a_ptr_zero_halt: assert property ((st_q == S_STOP) |->
        cur_q == 32'h0000_0000)
        else $error("pointer not cleared on halt");
    a_rel_clock_clear: assert property ((start_go && !no_clr_q) |=>
        pbclk_q == '0)
        else $error("relative start did not clear clock");
    a_abs_clock_keep: assert property ((start_go && no_clr_q &&
        !preset_hi_w && !preset_lo_w) |=> pbclk_q == $past(pbclk_q))
        else $error("absolute start changed clock");
    a_first_block_used: assert property (start_go |=>
        mem_req_o && mem_addr_o == $past(first_q) && cur_q == $past(first_q))
        else $error("start not at first block");
    a_skip_old_pkt: assert property ((st_q == S_EVAL && skip_q &&
        pkt_time < pbclk_q) |-> !enc_load)
        else $error("backed-up packet loaded");
    a_stopped_after_idle: assert property ($rose(stopped_q) |->
        st_q == S_IDLE && !enc_busy && $past(st_q) == S_STOP)
        else $error("stopped set while work pending");
    a_trig_hold_off: assert property (running && armed_q &&
        !trigd_q |-> !enc_start)
        else $error("sent before trigger");
    a_stop_irq_pulse: assert property ((st_q == S_STOP &&
        guard_q == 16'h0000 && stop_ien_q) |=> stop_irq_o ##1 !stop_irq_o)
        else $error("stop interrupt missing");
    a_start_fetch_soon: assert property (start_go |-> ##[1:2]
        mem_req_o)
        else $error("fetch not started");
    c_skip_seen: cover property (st_q == S_EVAL && skip_q &&
        pkt_time < pbclk_q);
    c_trig_start: cover property (armed_q && $rose(trigd_q));
    c_chain_next: cover property (st_q == S_BEND && !enc_busy && start_q &&
        next_q != 32'h0000_0000);
    c_stopped: cover property ($rose(stopped_q));
endmodule // tps_sequencer

// ### tps_sequencer_test.sv
// self-checking bench for the timed playback sequencer
`timescale 1ns/1ps
module tps_sequencer_test
    import tps_pkg::*;
;
    logic        sys_clk_i = 0, nrst_i = 0, hsel = 0, hwrite = 0;
    logic [1:0]  htrans = 0, tx_line_o, prev = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, mem_addr_o, mem_rdata_i;
    logic [31:0] r, sh, d[4], rxq[$], expq[$];
    logic        hreadyout, hresp, mem_req_o, mem_ack_i, stop_irq_o;
    int          fails = 0, checks = 0, cyc = 0, n = 0, t0, ts;
    tps_sequencer #(.GUARD_CYC(4), .HALF_CYC(2)) tps_sequencer_i (
        .sys_clk_i, .nrst_i, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .mem_req_o, .mem_addr_o, .mem_ack_i, .mem_rdata_i,
        .trig_i(1'b0), .normal_tx_busy_i(1'b0), .tx_line_o, .stop_irq_o);
    tps_mem_model tps_mem_model_i (.sys_clk_i, .mem_req_i(mem_req_o),
        .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i),
        .mem_rdata_o(mem_rdata_i));
    initial forever #20 sys_clk_i = ~sys_clk_i;
    task complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] v);
        htrans <= 2'h2;
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= v;
        do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task put3(input logic [31:0] a, x, y, z);
        tps_mem_model_i.mem[a[10:2]] = x;
        tps_mem_model_i.mem[a[10:2] + 1] = y;
        tps_mem_model_i.mem[a[10:2] + 2] = z;
    endtask
    // packets older than the preset clock are expected to vanish
    task pk(input logic [31:0] a, t, v, c0);
        put3(a, 32'h0, t, v);
        if (t >= c0) expq.push_back(v);
    endtask
    task play(input logic [31:0] ctl, blk, lo, hi);
        ahb(1'b1, TPS_OFS_CTRL, ctl);
        ahb(1'b1, TPS_OFS_FIRST_BLK, blk);
        ahb(1'b0, TPS_OFS_FIRST_BLK, 32'h0);
        chk(r, blk);
        ahb(1'b1, TPS_OFS_CONTROL_STATUS_WORD_ONE, 32'h4011 | ctl & 32'h20);
        ts = cyc;
        repeat (20) @(posedge sys_clk_i);
        ahb(1'b0, TPS_OFS_CUR_BLK, 32'h0);
        chk(r, blk);
        // force pulse only matters when the start was armed
        ahb(1'b1, TPS_OFS_CTRL, ctl | 32'h8);
        while (stop_irq_o !== 1'b1) @(posedge sys_clk_i);
        ahb(1'b0, TPS_OFS_CUR_BLK, 32'h0);
        chk(r, 32'h0);
        ahb(1'b0, TPS_OFS_CONTROL_STATUS_WORD_ONE, 32'h0);
        chk(r[1], 32'h1);
        ahb(1'b1, TPS_OFS_CONTROL_STATUS_WORD_ONE, 32'h12);
        ahb(1'b0, TPS_OFS_CONTROL_STATUS_WORD_ONE, 32'h0);
        chk(r, 32'h10);
        chk(tx_line_o, TPS_LINE_TRI);
        chk(32'(t0 - ts >= lo && t0 - ts <= hi), 32'h1);
        while (expq.size() > 0)
            chk(rxq.pop_front(), expq.pop_front());
        chk(rxq.size(), 32'h0);
        repeat (TPS_GUARD_CYC) @(posedge sys_clk_i);
    endtask
    // decode the line: a data half after mid or tri starts one bit
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        prev <= tx_line_o;
        if (cyc > 20000) begin
            fails++;
            complete_run();
        end
        if ((tx_line_o == TPS_LINE_HIGH || tx_line_o == TPS_LINE_LOW) &&
            (prev == TPS_LINE_MID || prev == TPS_LINE_TRI)) begin
            if (n == 0) t0 = cyc;
            sh = {tx_line_o == TPS_LINE_HIGH, sh[31:1]};
            n = n + 1;
            if (n == 32) rxq.push_back(sh);
            if (n == 32) n = 0;
        end
    end
    initial begin
        void'($urandom(32'hbf46));
        repeat (10) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        for (int i = 0; i < 4; i++) d[i] = $urandom();
        put3(32'h100, 32'h140, 32'h200, 32'h2);
        put3(32'h140, 32'h0, 32'h300, 32'h1);
        put3(32'h180, 32'h0, 32'h400, 32'h2);
        pk(32'h200, 32'h190, d[0], 32'h0);
        pk(32'h20c, 32'h76c, d[1], 32'h0);
        pk(32'h300, 32'hd48, d[2], 32'h0);
        play(32'h1, 32'h100, 32'h6a2, 32'h7b2);
        ahb(1'b1, TPS_OFS_CLK_HI, 32'h0);
        ahb(1'b1, TPS_OFS_CLK_LO, 32'h2710);
        pk(32'h400, 32'h1f4, d[3], 32'h2710);
        pk(32'h40c, 32'h2cec, d[0] ^ 32'h1, 32'h2710);
        play(32'h7, 32'h180, 32'h2ec, 32'h3fc);
        // armed start: clock frozen until the forced trigger
        pk(32'h300, 32'h190, d[3], 32'h0);
        play(32'h21, 32'h140, 32'hde, 32'h1ee);
        ahb(1'b0, 12'h0c0, 32'h0);
        chk(r, 32'h0);
        complete_run();
    end
endmodule // tps_sequencer_test

// ### tps_tx_encoder.sv
// transmit encoder: holds one packet until its time, then sends it
`timescale 1ns/1ps
module tps_tx_encoder
    import tps_pkg::*;
#(
    parameter int TW       = 64,
    parameter int HALF_CYC = TPS_HALF_BIT_CYC
) (
    input  wire logic          sys_clk_i,
    input  wire logic          nrst_i,
    input  wire logic          load_i,
    input  wire logic [TW-1:0] time_i,
    input  wire logic [31:0]   data_i,
    input  wire logic          go_i,
    input  wire logic [TW-1:0] pb_clk_i,
    output logic               busy_o,
    output logic               start_o,
    output logic [1:0]         line_o
);
    typedef enum logic [1:0] {
        E_IDLE = 2'b00,
        E_HOLD = 2'b01,
        E_SEND = 2'b10
    } tps_enc_st_t;

    tps_enc_st_t     st_q, st_d;
    logic [TW-1:0]   time_q, time_d;
    logic [31:0]     shf_q, shf_d;
    logic [5:0]      bit_q, bit_d;
    logic [15:0]     cnt_q, cnt_d;
    logic            half_q, half_d;
    logic [1:0]      line_q, line_d;
    logic            due;

    // full-width compare every cycle, one clock step is two 20 ns units
    assign due     = go_i && (time_q <= pb_clk_i);
    assign start_o = (st_q == E_HOLD) && due;
    assign busy_o  = (st_q != E_IDLE);

    always_comb begin
        st_d = st_q; time_d = time_q; shf_d = shf_q; bit_d = bit_q;
        cnt_d = cnt_q; half_d = half_q; line_d = line_q;
        unique case (st_q)
            E_IDLE: begin
                line_d = TPS_LINE_MID;
                if (load_i) begin
                    time_d = time_i;
                    shf_d  = data_i;
                    st_d   = E_HOLD;
                end
            end
            E_HOLD: begin
                if (due) begin
                    st_d   = E_SEND;
                    bit_d  = 6'(TPS_WORD_BITS - 1);
                    cnt_d  = 16'(HALF_CYC - 1);
                    half_d = 1'b0;
                    line_d = shf_q[0] ? TPS_LINE_HIGH : TPS_LINE_LOW;
                end
            end
            E_SEND: begin
                if (cnt_q != 16'h0000) begin
                    cnt_d = cnt_q - 16'h0001;
                end else if (!half_q) begin
                    half_d = 1'b1;
                    cnt_d  = 16'(HALF_CYC - 1);
                    line_d = TPS_LINE_MID;
                end else if (bit_q == 6'h00) begin
                    st_d   = E_IDLE;
                end else begin
                    shf_d  = {1'b0, shf_q[31:1]};
                    bit_d  = bit_q - 6'h01;
                    half_d = 1'b0;
                    cnt_d  = 16'(HALF_CYC - 1);
                    line_d = shf_q[1] ? TPS_LINE_HIGH : TPS_LINE_LOW;
                end
            end
            default: st_d = E_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st_q <= E_IDLE; time_q <= '0; shf_q <= 32'h0000_0000;
            bit_q <= 6'h00; cnt_q <= 16'h0000; half_q <= 1'b0;
            line_q <= TPS_LINE_MID;
        end else begin
            st_q <= st_d; time_q <= time_d; shf_q <= shf_d; bit_q <= bit_d;
            cnt_q <= cnt_d; half_q <= half_d; line_q <= line_d;
        end
    end
    assign line_o = line_q;

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_no_early_send: assert property (($rose(st_q == E_SEND)) |->
        $past(time_q) <= $past(pb_clk_i) && $past(go_i))
        else $error("packet sent before its time");
    a_hold_while_late: assert property ((st_q == E_HOLD && go_i &&
        time_q > pb_clk_i) |=> st_q == E_HOLD)
        else $error("late packet left hold");
endmodule // tps_tx_encoder
